// *** rtl/ptp_pkg.sv ***
// Package for the four-channel pulse-train positioning block
`default_nettype none
package ptp_pkg;
    localparam int NCH = 4;
    localparam int ADDR_W = 8;
    localparam int PER_W = 16;

    // Timing: clock period, 1 ms sample tick, 10 ms input filter
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_US = 1000;
    localparam int FILT_PERIOD_US = 10000;
    localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int FILT_CYCLES = FILT_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_W = 20;

    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_LIMIT = 8'h04;
    localparam logic [ADDR_W-1:0] REG_ARG = 8'h08;
    localparam logic [ADDR_W-1:0] REG_SPEED = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_CMD = 8'h10;
    localparam logic [ADDR_W-1:0] REG_BUSY = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_POS0 = 8'h20;
    localparam logic [ADDR_W-1:0] REG_ABSPOS = 8'h30;

    // Field positions
    localparam int CTRL_STOP_LSB = 0;
    localparam int CTRL_DECEL_OPT_BIT = 4;
    localparam int CTRL_FORMAT_BIT = 5;
    localparam int CTRL_SRC_LSB = 8;
    localparam int LIMIT_FWD_LSB = 0;
    localparam int LIMIT_REV_LSB = 4;
    localparam int SPEED_RUN_LSB = 0;
    localparam int SPEED_CREEP_LSB = 16;
    localparam int CMD_CH_LSB = 0;
    localparam int CMD_OP_LSB = 4;
    localparam int CMD_DIR_BIT = 8;
    localparam int STAT_DONE_LSB = 0;
    localparam int STAT_REFUSE_LSB = 4;

    // Reset values and motion constants
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SPEED_RST = 32'h03e8_0064;
    localparam logic [PER_W-1:0] DECEL_STEP = 16'h0010;
    localparam logic [PER_W-1:0] MIN_PERIOD = 16'h0002;

    typedef enum logic [3:0] {
        OP_FIXED_PULSE_OUTPUT = 4'h0,
        OP_RAMPED_PULSE_OUTPUT = 4'h1,
        OP_RELATIVE_MOVE = 4'h2,
        OP_ABSOLUTE_MOVE = 4'h3,
        OP_VARIABLE_SPEED_OUTPUT = 4'h4,
        OP_DOG_ZERO_PHASE_HOMING = 4'h5,
        OP_BASIC_ZERO_RETURN = 4'h6,
        OP_INTERRUPT_POSITIONING = 4'h7,
        OP_ABS_POSITION_READ = 4'h8
    } ptp_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RUN = 3'h1,
        ST_DECEL = 3'h2,
        ST_CREEP = 3'h3,
        ST_WAIT_ZERO = 3'h4
    } ptp_state_t;
endpackage : ptp_pkg
`default_nettype wire

// *** rtl/ptp_in_filter.sv ***
// Pin synchroniser with optional stable-time filter
`default_nettype none
module ptp_in_filter #(
    parameter int FILT_CYCLES = ptp_pkg::FILT_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic pin,
    output logic sync_out,
    output logic filt_out
);
    logic meta_q, sync_q, filt_q;
    logic filt_d;
    logic [ptp_pkg::CNT_W-1:0] cnt_q, cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        filt_d = filt_q;
        if (sync_q == filt_q) begin
            cnt_d = '0;
        end else if (cnt_q == ptp_pkg::CNT_W'(FILT_CYCLES - 1)) begin
            cnt_d = '0;
            filt_d = sync_q;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            filt_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            filt_q <= filt_d;
            cnt_q <= cnt_d;
        end
    end

    assign sync_out = sync_q;
    assign filt_out = filt_q;
endmodule : ptp_in_filter
`default_nettype wire

// *** rtl/ptp_top.sv ***
// Four-channel pulse-train positioning output with register port
`default_nettype none
module ptp_top #(
    parameter int TICK_CYCLES = ptp_pkg::TICK_CYCLES,
    parameter int FILT_CYCLES = ptp_pkg::FILT_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [ptp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [ptp_pkg::NCH-1:0] dog_pin,
    input wire logic [ptp_pkg::NCH-1:0] zero_phase_pin,
    output logic [ptp_pkg::NCH-1:0] pulse_a_out,
    output logic [ptp_pkg::NCH-1:0] pulse_b_out,
    output logic irq
);
    localparam int N = ptp_pkg::NCH;
    localparam int PW = ptp_pkg::PER_W;

    // Software registers
    logic [31:0] ctrl_q, ctrl_d, limit_q, limit_d, arg_q, arg_d, speed_q, speed_d;
    logic [31:0] abspos_q, abspos_d, rdata_q, rdata_d;
    logic [7:0] status_q, status_d, mask_q, mask_d;
    logic [ptp_pkg::CNT_W-1:0] tick_cnt_q, tick_cnt_d;
    logic tick;

    // Per-channel state
    ptp_pkg::ptp_state_t st_q [N];
    ptp_pkg::ptp_state_t st_d [N];
    ptp_pkg::ptp_op_t op_q [N];
    ptp_pkg::ptp_op_t op_d [N];
    logic [31:0] pos_q [N];
    logic [31:0] pos_d [N];
    logic [31:0] rem_q [N];
    logic [31:0] rem_d [N];
    logic [PW-1:0] per_q [N];
    logic [PW-1:0] per_d [N];
    logic [PW-1:0] cnt_q [N];
    logic [PW-1:0] cnt_d [N];
    logic [N-1:0] dir_q, dir_d, lim_q, lim_d, armed_q, armed_d;
    logic [N-1:0] dog_prev_q, dog_tick_q, dog_tick_d, zp_prev_q;
    logic [N-1:0] pa_q, pa_d, pb_q, pb_d;
    logic [N-1:0] busy, start, refuse, done;
    logic [N-1:0] dog_sync, dog_filt, dog_sel, zp_sync;

    // Command decode
    logic cmd_wr;
    logic [1:0] cmd_ch;
    ptp_pkg::ptp_op_t cmd_op;
    logic cmd_dir, cmd_exempt;
    assign cmd_wr = reg_wr && (reg_addr == ptp_pkg::REG_CMD);
    assign cmd_ch = reg_wdata[ptp_pkg::CMD_CH_LSB +: 2];
    assign cmd_op = ptp_pkg::ptp_op_t'(reg_wdata[ptp_pkg::CMD_OP_LSB +: 4]);
    assign cmd_dir = reg_wdata[ptp_pkg::CMD_DIR_BIT];
    assign cmd_exempt = (cmd_op == ptp_pkg::OP_ABS_POSITION_READ);

    // 1 ms sample tick
    always_comb begin
        tick = (tick_cnt_q == ptp_pkg::CNT_W'(TICK_CYCLES - 1));
        tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
    end

    // Register bus, sticky status cleared by read
    always_comb begin
        ctrl_d = ctrl_q;
        limit_d = limit_q;
        arg_d = arg_q;
        speed_d = speed_q;
        mask_d = mask_q;
        abspos_d = abspos_q;
        rdata_d = '0;
        status_d = status_q;
        if (reg_wr) begin
            if (reg_addr == ptp_pkg::REG_CTRL) begin
                ctrl_d = reg_wdata;
            end else if (reg_addr == ptp_pkg::REG_LIMIT) begin
                limit_d = reg_wdata;
            end else if (reg_addr == ptp_pkg::REG_ARG) begin
                arg_d = reg_wdata;
            end else if (reg_addr == ptp_pkg::REG_SPEED) begin
                speed_d = reg_wdata;
            end else if (reg_addr == ptp_pkg::REG_MASK) begin
                mask_d = reg_wdata[7:0];
            end
        end
        if (cmd_wr && cmd_exempt) begin
            abspos_d = pos_q[cmd_ch];
        end
        if (reg_rd) begin
            if (reg_addr == ptp_pkg::REG_CTRL) begin
                rdata_d = ctrl_q;
            end else if (reg_addr == ptp_pkg::REG_LIMIT) begin
                rdata_d = limit_q;
            end else if (reg_addr == ptp_pkg::REG_ARG) begin
                rdata_d = arg_q;
            end else if (reg_addr == ptp_pkg::REG_SPEED) begin
                rdata_d = speed_q;
            end else if (reg_addr == ptp_pkg::REG_BUSY) begin
                rdata_d = {28'h0, busy};
            end else if (reg_addr == ptp_pkg::REG_STATUS) begin
                rdata_d = {24'h0, status_q};
                status_d = '0;
            end else if (reg_addr == ptp_pkg::REG_MASK) begin
                rdata_d = {24'h0, mask_q};
            end else if (reg_addr == ptp_pkg::REG_ABSPOS) begin
                rdata_d = abspos_q;
            end else if (reg_addr[7:4] == ptp_pkg::REG_POS0[7:4] && reg_addr[1:0] == 2'h0) begin
                rdata_d = pos_q[reg_addr[3:2]];
            end
        end
        // New events win over the read clear
        status_d[ptp_pkg::STAT_DONE_LSB +: N] = status_d[ptp_pkg::STAT_DONE_LSB +: N] | done;
        status_d[ptp_pkg::STAT_REFUSE_LSB +: N] = status_d[ptp_pkg::STAT_REFUSE_LSB +: N] | refuse;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= ptp_pkg::CTRL_RST;
            limit_q <= '0;
            arg_q <= '0;
            speed_q <= ptp_pkg::SPEED_RST;
            mask_q <= '0;
            status_q <= '0;
            abspos_q <= '0;
            rdata_q <= '0;
            tick_cnt_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            limit_q <= limit_d;
            arg_q <= arg_d;
            speed_q <= speed_d;
            mask_q <= mask_d;
            status_q <= status_d;
            abspos_q <= abspos_d;
            rdata_q <= rdata_d;
            tick_cnt_q <= tick_cnt_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = |(status_q & mask_q);
    assign pulse_a_out = pa_q;
    assign pulse_b_out = pb_q;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            ptp_in_filter #(
                .FILT_CYCLES(FILT_CYCLES)
            ) u_dog (
                .clk(clk),
                .srst(srst),
                .pin(dog_pin[i]),
                .sync_out(dog_sync[i]),
                .filt_out(dog_filt[i])
            );
            ptp_in_filter #(
                .FILT_CYCLES(FILT_CYCLES)
            ) u_zp (
                .clk(clk),
                .srst(srst),
                .pin(zero_phase_pin[i]),
                .sync_out(zp_sync[i]),
                .filt_out()
            );

            logic stop_cmd, fwd_lim, rev_lim, lim_hit, step, lead, trail_zrn, trail_tick, zp_rise;
            logic counting, homing, line;
            logic [31:0] delta;
            logic [PW-1:0] run_per, creep_per;

            assign busy[i] = (st_q[i] != ptp_pkg::ST_IDLE);
            assign start[i] = cmd_wr && cmd_ch == 2'(i) && !busy[i] && !cmd_exempt;
            assign refuse[i] = cmd_wr && cmd_ch == 2'(i) && busy[i] && !cmd_exempt;
            assign dog_sel[i] = ctrl_q[ptp_pkg::CTRL_SRC_LSB + i] ? dog_filt[i] : dog_sync[i];

            always_comb begin
                stop_cmd = ctrl_q[ptp_pkg::CTRL_STOP_LSB + i];
                fwd_lim = limit_q[ptp_pkg::LIMIT_FWD_LSB + i];
                rev_lim = limit_q[ptp_pkg::LIMIT_REV_LSB + i];
                lim_hit = dir_q[i] ? rev_lim : fwd_lim;
                run_per = speed_q[ptp_pkg::SPEED_RUN_LSB +: PW];
                creep_per = speed_q[ptp_pkg::SPEED_CREEP_LSB +: PW];
                if (run_per < ptp_pkg::MIN_PERIOD) run_per = ptp_pkg::MIN_PERIOD;
                if (creep_per < ptp_pkg::MIN_PERIOD) creep_per = ptp_pkg::MIN_PERIOD;
                lead = dog_sel[i] && !dog_prev_q[i];
                trail_zrn = !dog_sel[i] && dog_prev_q[i];
                trail_tick = tick && dog_tick_q[i] && !dog_sel[i];
                zp_rise = zp_sync[i] && !zp_prev_q[i];
                homing = op_q[i] == ptp_pkg::OP_DOG_ZERO_PHASE_HOMING || op_q[i] == ptp_pkg::OP_BASIC_ZERO_RETURN;
                counting = !homing && op_q[i] != ptp_pkg::OP_VARIABLE_SPEED_OUTPUT
                    && (op_q[i] != ptp_pkg::OP_INTERRUPT_POSITIONING || armed_q[i]);
                step = busy[i] && cnt_q[i] == per_q[i] - 1'b1;
                delta = (cmd_op == ptp_pkg::OP_ABSOLUTE_MOVE) ? arg_q - pos_q[i] : arg_q;
                st_d[i] = st_q[i];
                op_d[i] = op_q[i];
                pos_d[i] = pos_q[i];
                rem_d[i] = rem_q[i];
                per_d[i] = per_q[i];
                dir_d[i] = dir_q[i];
                lim_d[i] = lim_q[i];
                armed_d[i] = armed_q[i];
                dog_tick_d[i] = tick ? dog_sel[i] : dog_tick_q[i];
                done[i] = 1'b0;
                cnt_d[i] = (!busy[i] || step) ? '0 : cnt_q[i] + 1'b1;
                // Position follows the direction line only; no backlash fix-up
                if (step) begin
                    pos_d[i] = dir_q[i] ? pos_q[i] - 1'b1 : pos_q[i] + 1'b1;
                    if (counting) rem_d[i] = rem_q[i] - 1'b1;
                end
                case (st_q[i])
                    ptp_pkg::ST_IDLE: begin
                        if (start[i]) begin
                            op_d[i] = cmd_op;
                            per_d[i] = run_per;
                            lim_d[i] = 1'b0;
                            armed_d[i] = 1'b0;
                            dir_d[i] = cmd_dir;
                            rem_d[i] = delta;
                            if (cmd_op == ptp_pkg::OP_RELATIVE_MOVE || cmd_op == ptp_pkg::OP_ABSOLUTE_MOVE) begin
                                dir_d[i] = delta[31];
                                rem_d[i] = delta[31] ? -delta : delta;
                            end else if (cmd_op == ptp_pkg::OP_FIXED_PULSE_OUTPUT
                                || cmd_op == ptp_pkg::OP_RAMPED_PULSE_OUTPUT) begin
                                dir_d[i] = 1'b0;
                            end
                            if (rem_d[i] == '0 && (cmd_op == ptp_pkg::OP_RELATIVE_MOVE
                                || cmd_op == ptp_pkg::OP_ABSOLUTE_MOVE || cmd_op == ptp_pkg::OP_FIXED_PULSE_OUTPUT
                                || cmd_op == ptp_pkg::OP_RAMPED_PULSE_OUTPUT)) begin
                                done[i] = 1'b1;
                            end else begin
                                st_d[i] = ptp_pkg::ST_RUN;
                            end
                        end
                    end
                    ptp_pkg::ST_RUN: begin
                        if (counting && step && rem_q[i] == 32'h1) begin
                            st_d[i] = ptp_pkg::ST_IDLE;
                            done[i] = 1'b1;
                        end else if (homing && lead) begin
                            st_d[i] = ptp_pkg::ST_DECEL;
                        end else if (op_q[i] == ptp_pkg::OP_INTERRUPT_POSITIONING && !armed_q[i] && lead) begin
                            armed_d[i] = 1'b1;
                            rem_d[i] = arg_q[31] ? -arg_q : arg_q;
                        end
                    end
                    ptp_pkg::ST_DECEL: begin
                        if (step) begin
                            per_d[i] = per_q[i] + ptp_pkg::DECEL_STEP;
                        end
                        if (counting && step && rem_q[i] == 32'h1) begin
                            st_d[i] = ptp_pkg::ST_IDLE;
                            done[i] = 1'b1;
                        end else if (step && per_d[i] >= creep_per) begin
                            if (homing && !lim_q[i]) begin
                                per_d[i] = creep_per;
                                st_d[i] = ptp_pkg::ST_CREEP;
                            end else begin
                                st_d[i] = ptp_pkg::ST_IDLE;
                                done[i] = 1'b1;
                            end
                        end
                    end
                    ptp_pkg::ST_CREEP: begin
                        if (op_q[i] == ptp_pkg::OP_BASIC_ZERO_RETURN && trail_zrn) begin
                            st_d[i] = ptp_pkg::ST_IDLE;
                            pos_d[i] = '0;
                            done[i] = 1'b1;
                        end else if (op_q[i] == ptp_pkg::OP_DOG_ZERO_PHASE_HOMING && trail_tick) begin
                            st_d[i] = ptp_pkg::ST_WAIT_ZERO;
                        end
                    end
                    ptp_pkg::ST_WAIT_ZERO: begin
                        if (zp_rise) begin
                            st_d[i] = ptp_pkg::ST_IDLE;
                            pos_d[i] = '0;
                            done[i] = 1'b1;
                        end
                    end
                    default: begin
                        st_d[i] = ptp_pkg::ST_IDLE;
                    end
                endcase
                // Stop and limit checks override the normal sequence
                if (busy[i] && stop_cmd) begin
                    st_d[i] = ptp_pkg::ST_IDLE;
                    done[i] = 1'b1;
                end else if (busy[i] && lim_hit && !lim_q[i]) begin
                    if ((op_q[i] == ptp_pkg::OP_VARIABLE_SPEED_OUTPUT && !ctrl_q[ptp_pkg::CTRL_DECEL_OPT_BIT])
                        || op_q[i] == ptp_pkg::OP_FIXED_PULSE_OUTPUT
                        || op_q[i] == ptp_pkg::OP_RAMPED_PULSE_OUTPUT) begin
                        st_d[i] = ptp_pkg::ST_IDLE;
                        done[i] = 1'b1;
                    end else begin
                        st_d[i] = ptp_pkg::ST_DECEL;
                        lim_d[i] = 1'b1;
                    end
                end
                if (st_d[i] == ptp_pkg::ST_IDLE) cnt_d[i] = '0;
                line = (st_d[i] != ptp_pkg::ST_IDLE) && (cnt_d[i] < (per_d[i] >> 1));
                if (ctrl_q[ptp_pkg::CTRL_FORMAT_BIT]) begin
                    pa_d[i] = line;
                    pb_d[i] = dir_d[i];
                end else begin
                    pa_d[i] = line && !dir_d[i];
                    pb_d[i] = line && dir_d[i];
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    st_q[i] <= ptp_pkg::ST_IDLE;
                    op_q[i] <= ptp_pkg::OP_FIXED_PULSE_OUTPUT;
                    pos_q[i] <= '0;
                    rem_q[i] <= '0;
                    per_q[i] <= ptp_pkg::MIN_PERIOD;
                    cnt_q[i] <= '0;
                    dir_q[i] <= 1'b0;
                    lim_q[i] <= 1'b0;
                    armed_q[i] <= 1'b0;
                    dog_prev_q[i] <= 1'b0;
                    dog_tick_q[i] <= 1'b0;
                    zp_prev_q[i] <= 1'b0;
                    pa_q[i] <= 1'b0;
                    pb_q[i] <= 1'b0;
                end else begin
                    st_q[i] <= st_d[i];
                    op_q[i] <= op_d[i];
                    pos_q[i] <= pos_d[i];
                    rem_q[i] <= rem_d[i];
                    per_q[i] <= per_d[i];
                    cnt_q[i] <= cnt_d[i];
                    dir_q[i] <= dir_d[i];
                    lim_q[i] <= lim_d[i];
                    armed_q[i] <= armed_d[i];
                    dog_prev_q[i] <= dog_sel[i];
                    dog_tick_q[i] <= dog_tick_d[i];
                    zp_prev_q[i] <= zp_sync[i];
                    pa_q[i] <= pa_d[i];
                    pb_q[i] <= pb_d[i];
                end
            end
        end
    endgenerate
endmodule : ptp_top
`default_nettype wire

// *** bench/ptp_props.sv ***
// Port checker for the pulse-train positioning block
`default_nettype none
module ptp_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [3:0] pulse_a_out,
    input wire logic [3:0] pulse_b_out,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] ctrl_q;
    logic [7:0] mask_q;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    // Shadows of control and mask, and of a stop flag held two edges
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= 12'h0;
            mask_q <= 8'h0;
            s1_q <= 4'h0;
            s2_q <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == ptp_pkg::REG_CTRL) ctrl_q <= reg_wdata[11:0] & 12'hf3f;
            if (reg_wr && reg_addr == ptp_pkg::REG_MASK) mask_q <= reg_wdata[7:0];
            s1_q <= ctrl_q[3:0];
            s2_q <= s1_q & ctrl_q[3:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data off slot");
    unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 32'h0) else $error("unmapped");
    ctrl_readback_a: assert property (reg_rd && reg_addr == ptp_pkg::REG_CTRL |=>
        (reg_rdata[11:0] & 12'hf3f) == $past(ctrl_q)) else $error("control readback");
    mask_readback_a: assert property (reg_rd && reg_addr == ptp_pkg::REG_MASK ##1 1'b1 |->
        reg_rdata[7:0] == $past(mask_q)) else $error("mask readback");
    stop_quiet_a: assert property (((pulse_a_out | (ctrl_q[5] ? 4'h0 : pulse_b_out)) & s2_q) == 4'h0)
        else $error("pulse while stopped");
    stop_idle_a: assert property (reg_rd && reg_addr == ptp_pkg::REG_BUSY |=>
        (reg_rdata[3:0] & $past(s2_q)) == 4'h0) else $error("busy while stopped");
    fwdrev_excl_a: assert property (!ctrl_q[5] |-> (pulse_a_out & pulse_b_out) == 4'h0) else $error("both trains");
    irq_masked_a: assert property (irq |-> mask_q != 8'h0) else $error("irq with all masked");
endmodule : ptp_props
bind ptp_top ptp_props ptp_props_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pulse_a_out(pulse_a_out),
    .pulse_b_out(pulse_b_out), .irq(irq));
`default_nettype wire

// *** bench/ptp_drive.sv ***
// Drive-unit model: counts decoded pulses and makes the zero phase
`default_nettype none
module ptp_drive (
    input wire logic clk,
    input wire logic fmt,
    input wire logic [3:0] pa,
    input wire logic [3:0] pb,
    output logic [3:0] zp,
    output int pos [4]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pa_q = 4'h0;
    logic [3:0] pb_q = 4'h0;
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            pos[i] <= pos[i] + ((pa[i] && !pa_q[i]) ? ((fmt && pb[i]) ? -1 : 1) : 0)
                - ((!fmt && pb[i] && !pb_q[i]) ? 1 : 0);
        end
        pa_q <= pa;
        pb_q <= pb;
    end
    // Zero phase once every four pulses on pa
    always_comb for (int i = 0; i < 4; i++) zp[i] = pa[i] && pos[i][1:0] == 2'h0;
endmodule : ptp_drive
`default_nettype wire

// *** bench/ptp_top_tb.sv ***
// Register-level testbench for the pulse-train positioning block
`default_nettype none
module ptp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] dog = 4'h0;
    logic fmt = 1'b0;
    logic [31:0] rdata, rv;
    logic [3:0] zp, pa, pb;
    logic irq, iv;
    int pos [4];
    int base;
    int miscompares = 0;
    int check_count = 0;
    always #10 clk = ~clk;
    ptp_top #(.TICK_CYCLES(20), .FILT_CYCLES(8)) ptp_top_i (.clk(clk), .srst(srst), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .dog_pin(dog),
        .zero_phase_pin(zp), .pulse_a_out(pa), .pulse_b_out(pb), .irq(irq));
    ptp_drive ptp_drive_i (.clk(clk), .fmt(fmt), .pa(pa), .pb(pb), .zp(zp), .pos(pos));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wreg
    task automatic rreg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        rv = rdata;
        iv = irq;
        @(posedge clk);
    endtask : rreg
    task automatic cmd(input logic [1:0] ch, input logic [3:0] op, input logic dir, input logic [31:0] arg);
        wreg(8'h08, arg);
        wreg(8'h10, {23'h0, dir, op, 2'h0, ch});
    endtask : cmd
    task automatic idle(input int ch);
        repeat (3000) begin
            rreg(8'h14);
            if (rv[ch] === 1'b0) break;
        end
        chk(rv[ch], 1'b0);
    endtask : idle
    task automatic home(input logic [3:0] op);
        cmd(3, op, 1'b0, 0);
        repeat (50) @(posedge clk);
        dog[3] <= 1'b1;
        repeat (1500) @(posedge clk);
        dog[3] <= 1'b0;
        idle(3);
        rreg(8'h2c);
        chk(rv, 32'h0);
    endtask : home
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rreg(8'h0c);
        chk(rv, ptp_pkg::SPEED_RST);
        rreg(8'h40);
        chk(rv, 32'h0);
        wreg(8'h0c, 32'h0064_0004);
        wreg(8'h1c, 32'h1);
        rreg(8'h1c);
        chk(rv, 32'h1);
        cmd(0, 4'h2, 1'b0, 20);
        rreg(8'h14);
        chk(rv, 32'h1);
        cmd(0, 4'h2, 1'b0, 20);
        rreg(8'h18);
        chk(rv, 32'h10);
        cmd(0, 4'h8, 1'b0, 0);
        rreg(8'h18);
        chk(rv, 32'h0);
        idle(0);
        chk(iv, 1'b1);
        rreg(8'h18);
        chk(rv, 32'h1);
        rreg(8'h20);
        chk(rv, 32'd20);
        chk(iv, 1'b0);
        chk(pos[0], 32'd20);
        for (int c = 1; c < 4; c++) cmd(2'(c), c == 2 ? 4'h1 : 4'h0, 1'b0, 3);
        for (int c = 1; c < 4; c++) begin
            idle(c);
            rreg(8'(8'h20 + 4 * c));
            chk(rv, 32'd3);
            chk(pos[c], 32'd3);
        end
        cmd(1, 4'h8, 1'b0, 0);
        rreg(8'h30);
        chk(rv, 32'd3);
        fmt <= 1'b1;
        wreg(8'h00, 32'h20);
        rreg(8'h00);
        chk(rv, 32'h20);
        cmd(1, 4'h2, 1'b0, -3);
        idle(1);
        chk(pos[1], 32'd0);
        cmd(1, 4'h3, 1'b0, 2);
        idle(1);
        rreg(8'h24);
        chk(rv, 32'd2);
        chk(pos[1], 32'd2);
        fmt <= 1'b0;
        wreg(8'h00, 32'h0);
        cmd(1, 4'h4, 1'b1, 0);
        repeat (20) @(posedge clk);
        wreg(8'h00, 32'h2);
        rreg(8'h14);
        chk(rv, 32'h0);
        wreg(8'h00, 32'h0);
        for (int d = 0; d < 2; d++) begin
            cmd(2, 4'h4, d[0], 0);
            wreg(8'h04, d ? 32'h40 : 32'h4);
            rreg(8'h14);
            chk(rv, 32'h0);
            wreg(8'h04, 32'h0);
        end
        wreg(8'h00, 32'h10);
        cmd(2, 4'h4, 1'b0, 0);
        wreg(8'h04, 32'h4);
        rreg(8'h14);
        chk(rv, 32'h4);
        idle(2);
        wreg(8'h04, 32'h0);
        wreg(8'h00, 32'h800);
        home(4'h6);
        wreg(8'h00, 32'h0);
        home(4'h5);
        base = pos[3];
        cmd(3, 4'h7, 1'b0, 5);
        repeat (30) @(posedge clk);
        dog[3] <= 1'b1;
        idle(3);
        rreg(8'h2c);
        chk(rv, pos[3] - base);
        end_sim();
    end
endmodule : ptp_top_tb
`default_nettype wire
